/* File: core/dmc_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none

module dmc_ctrl
  import dmc_pkg::*;
#(
  parameter int unsigned PWR_CYC = C_PWR
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              req_valid,
  input  wire dmc_req_t          req,
  input  wire logic              req_page,
  output logic                   req_ready,
  output logic                   rd_valid,
  output logic [DATA_W-1:0]      rd_data,
  output dmc_pins_t              pins,
  input  wire logic [DATA_W-1:0] dq_i
);

  // ==========================================================
  // Pin input synchroniser
  // Only the second stage is read; the first may still be settling
  logic [DATA_W-1:0] dq_s1_q, dq_s2_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dq_s1_q <= '0;
      dq_s2_q <= '0;
    end else begin
      dq_s1_q <= dq_i;
      dq_s2_q <= dq_s1_q;
    end
  end

  // ==========================================================
  // State and registers
  dmc_state_t        st_q, st_d;
  logic [CNT_W-1:0]  cnt_q, cnt_d;
  logic [CNT_W-1:0]  ref_q;
  logic [ROW_W-1:0]  rrow_q;
  logic [3:0]        init_q;
  logic              refr_q, refr_d;
  dmc_req_t          cur_q;
  logic              open_q, open_d;
  dmc_pins_t         pins_d;
  logic              rdv_d;
  logic [DATA_W-1:0] rdd_d;

  wire logic cnt_done  = (cnt_q == '0);
  wire logic init_done = (init_q == 4'(INIT_CYC));
  wire logic ref_due   = (ref_q == '0) || !init_done;
  wire logic take      = req_valid && req_ready;
  wire logic page_hit  = open_q && req_valid && req_page
                         && (req.row == cur_q.row) && !ref_due;

  function automatic logic [CNT_W-1:0] ld(input int unsigned c);
    return CNT_W'(c - 1);
  endfunction : ld

  // ==========================================================
  // Sequencer
  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_done ? cnt_q : cnt_q - 1'b1;
    refr_d = refr_q;
    open_d = open_q;
    pins_d = pins;
    rdv_d  = 1'b0;
    rdd_d  = rd_data;
    case (st_q)
      DMC_PWR: begin
        pins_d.ras_n = 1'b1;
        if (cnt_done) st_d = DMC_IDLE;
      end
      DMC_IDLE: begin
        // Refresh wins over a waiting request, which stays pending
        if (cnt_done && (ref_due || req_valid)) begin
          refr_d       = ref_due;
          pins_d.addr  = ref_due ? rrow_q : req.row;
          pins_d.ras_n = 1'b0;
          st_d         = DMC_RAS;
          cnt_d        = ld(C_RCD);
        end
      end
      DMC_RAS: begin
        if (cnt_done) begin
          if (refr_q) begin
            st_d  = DMC_CHI;
            cnt_d = ld(C_RAS - C_RCD);
          end else begin
            // Column bits ride on A1..A6
            pins_d.addr    = {1'b0, cur_q.col, 1'b0};
            pins_d.w_n     = !cur_q.we;
            pins_d.dq_o    = cur_q.wdata;
            pins_d.dq_oe_n = cur_q.we ? '0 : '1;
            // Output enable stays high whenever the bus is driven
            pins_d.g_n     = cur_q.we;
            st_d           = DMC_CAS;
          end
        end
      end
      DMC_CAS: begin
        // One device: its column strobe is the select; nothing is decoded here
        pins_d.cas_n = 1'b0;
        st_d         = DMC_RDWT;
        cnt_d        = ld(cur_q.we ? C_CAS : C_ACC);
      end
      DMC_RDWT: begin
        if (cnt_done) begin
          if (!cur_q.we) begin
            // Sampling late in the window absorbs the synchroniser's two cycles
            rdv_d = 1'b1;
            rdd_d = dq_s2_q;
          end
          st_d = DMC_CHI;
        end
      end
      DMC_CHI: begin
        pins_d.cas_n   = 1'b1;
        pins_d.g_n     = 1'b1;
        pins_d.dq_oe_n = '1;
        pins_d.w_n     = 1'b1;
        // A page hit keeps the row open; a due refresh closes it first
        if (!refr_q && page_hit) begin
          st_d   = DMC_PRE;
          open_d = 1'b1;
          cnt_d  = ld(C_CP);
        end else begin
          st_d  = DMC_RHI;
          cnt_d = ld(C_RAS);
        end
      end
      DMC_PRE: begin
        if (cnt_done) st_d = DMC_RAS;
      end
      DMC_RHI: begin
        if (cnt_done) begin
          pins_d.ras_n = 1'b1;
          open_d       = 1'b0;
          st_d         = DMC_IDLE;
          cnt_d        = ld(C_RP);
        end
      end
      default: st_d = DMC_IDLE;
    endcase
    if (take && st_q == DMC_RHI && cnt_done) open_d = 1'b0;
    if (st_q == DMC_RAS && !refr_q && cnt_done) open_d = 1'b1;
  end

  // Requests are taken when a row opens, or on a page hit
  assign req_ready = ((st_q == DMC_IDLE) && cnt_done && !ref_due)
                     || ((st_q == DMC_CHI) && page_hit);

  // ==========================================================
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q    <= DMC_PWR;
      cnt_q   <= CNT_W'(PWR_CYC - 1);
      refr_q  <= 1'b0;
      open_q  <= 1'b0;
      cur_q   <= '0;
      rd_valid <= 1'b0;
      rd_data <= '0;
      pins    <= '{ras_n: 1'b1, cas_n: 1'b1, w_n: 1'b1, g_n: 1'b1,
                   addr: '0, dq_o: '0, dq_oe_n: '1};
    end else begin
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      refr_q   <= refr_d;
      open_q   <= open_d;
      rd_valid <= rdv_d;
      rd_data  <= rdd_d;
      pins     <= pins_d;
      if (take) cur_q <= req;
    end
  end

  // ==========================================================
  // Refresh pacing: one row per interval, rows walk in order
  // The first eight refreshes are the init cycles; requests wait for them
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ref_q  <= CNT_W'(C_REF_INT - 1);
      rrow_q <= '0;
      init_q <= '0;
    end else begin
      if (st_q == DMC_RAS && refr_q && cnt_done) begin
        ref_q  <= CNT_W'(C_REF_INT - 1);
        rrow_q <= rrow_q + 1'b1;
        if (!init_done) init_q <= init_q + 1'b1;
      end else if (ref_q != '0) begin
        ref_q <= ref_q - 1'b1;
      end
    end
  end

endmodule : dmc_ctrl

`default_nettype wire

/* File: core/dmc_pkg.sv */
`default_nettype none

package dmc_pkg;

  // ==========================================================
  // Geometry
  localparam int unsigned ROW_W   = 8;
  localparam int unsigned COL_W   = 6;
  localparam int unsigned DATA_W  = 4;
  localparam int unsigned ROWS    = 256;
  localparam int unsigned CLK_MHZ = 100;

  // ==========================================================
  // Timing, in ns, and derived cycle counts (least times round up)
  localparam int unsigned T_RP_NS   = 120;
  localparam int unsigned T_RCD_NS  = 25;
  localparam int unsigned T_RAS_NS  = 200;
  localparam int unsigned T_CAS_NS  = 120;
  localparam int unsigned T_CP_NS   = 80;
  localparam int unsigned T_ACC_NS  = 200;
  localparam int unsigned T_GHD_NS  = 40;
  localparam int unsigned T_WP_NS   = 50;
  localparam int unsigned T_PWR_US  = 100;
  localparam int unsigned T_REF_MS  = 4;
  localparam int unsigned INIT_CYC  = 8;

  function automatic int unsigned ns2cyc(input int unsigned ns);
    int unsigned c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c == 0) ? 1 : c;
  endfunction : ns2cyc

  localparam int unsigned C_RP   = ns2cyc(T_RP_NS);
  localparam int unsigned C_RCD  = ns2cyc(T_RCD_NS);
  localparam int unsigned C_RAS  = ns2cyc(T_RAS_NS);
  localparam int unsigned C_CAS  = ns2cyc(T_CAS_NS);
  localparam int unsigned C_CP   = ns2cyc(T_CP_NS);
  localparam int unsigned C_ACC  = ns2cyc(T_ACC_NS);
  localparam int unsigned C_GHD  = ns2cyc(T_GHD_NS);
  localparam int unsigned C_WP   = ns2cyc(T_WP_NS);
  localparam int unsigned C_PWR  = T_PWR_US * CLK_MHZ;
  // Longest time rounds down: spread 256 rows over 4 ms
  localparam int unsigned C_REF_INT = (T_REF_MS * 1000 * CLK_MHZ) / ROWS;

  localparam int unsigned CNT_W = 16;

  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    DMC_PWR   = 4'h0,
    DMC_IDLE  = 4'h1,
    DMC_RAS   = 4'h3,
    DMC_CAS   = 4'h2,
    DMC_RDWT  = 4'h6,
    DMC_GHI   = 4'h7,
    DMC_WLOW  = 4'h5,
    DMC_CHI   = 4'h4,
    DMC_RHI   = 4'hc,
    DMC_PRE   = 4'hd
  } dmc_state_t;

  typedef struct packed {
    logic              we;
    logic [ROW_W-1:0]  row;
    logic [COL_W-1:0]  col;
    logic [DATA_W-1:0] wdata;
  } dmc_req_t;

  typedef struct packed {
    logic              ras_n;
    logic              cas_n;
    logic              w_n;
    logic              g_n;
    logic [ROW_W-1:0]  addr;
    logic [DATA_W-1:0] dq_o;
    logic [DATA_W-1:0] dq_oe_n;
  } dmc_pins_t;

endpackage : dmc_pkg

`default_nettype wire

/* File: dv/dmc_dram_mdl.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Device model; a floating bus shows the inverted word
module dmc_dram_mdl
  import dmc_pkg::*;
#(
  parameter int ACC_NS = 30
) (
  input  wire dmc_pins_t    pins,
  output logic [DATA_W-1:0] dq
);
  logic [DATA_W-1:0] mem [16384];
  logic [13:0]       loc;
  logic              ewr;
  wire               drv = !pins.ras_n && !pins.cas_n && !pins.g_n && !ewr;
  always @(negedge pins.ras_n) loc[13:6] = pins.addr;
  always @(negedge pins.cas_n) begin
    loc[5:0] = pins.addr[6:1];
    ewr = !pins.w_n;
    if (ewr) mem[loc] = pins.dq_o;
  end
  always @(negedge pins.w_n) if (!pins.cas_n) mem[loc] = pins.dq_o;
  // Late data so a controller sampling too early reads the inverted word
  assign #(ACC_NS) dq = drv ? mem[loc] : ~mem[loc];
endmodule : dmc_dram_mdl
`default_nettype wire

/* File: dv/dmc_ctrl_chk.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Pin timing of the controller
module dmc_ctrl_chk
  import dmc_pkg::*;
#(
  parameter int unsigned PWR_CYC = C_PWR
) (
  input wire logic      clk,
  input wire logic      nrst,
  input wire logic      req_ready,
  input wire logic      rd_valid,
  input wire dmc_pins_t pins
);
  int unsigned pwr_q;
  int unsigned gap_q;
  logic [3:0]  ini_q;
  logic        ras_q;
  // Edge seen by hand; reset to the idle level so no false fall follows reset
  wire logic   ras_fell = ras_q && !pins.ras_n;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pwr_q <= 0;
      gap_q <= 0;
      ini_q <= 4'h0;
      ras_q <= 1'b1;
    end else begin
      ras_q <= pins.ras_n;
      pwr_q <= (pwr_q < PWR_CYC) ? pwr_q + 1 : pwr_q;
      gap_q <= (ras_fell || pwr_q < PWR_CYC) ? 0 : gap_q + 1;
      ini_q <= (ras_fell && ini_q < 8) ? ini_q + 4'h1 : ini_q;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_float; !(&pins.dq_oe_n) |-> pins.g_n; endproperty
  a_float: assert property (p_float) else $error("bus driven, g low");
  property p_caddr; $fell(pins.cas_n) |-> $stable(pins.addr); endproperty
  a_caddr: assert property (p_caddr) else $error("addr moved at cas");
  property p_pwr; pwr_q < PWR_CYC |-> pins.ras_n; endproperty
  a_pwr: assert property (p_pwr) else $error("ras low in power-up");
  property p_init; ini_q < 8 |-> !req_ready; endproperty
  a_init: assert property (p_init) else $error("ready before init");
  property p_rcd; $fell(pins.ras_n) |-> ##1 pins.cas_n [*2]; endproperty
  a_rcd: assert property (p_rcd) else $error("ras to cas short");
  property p_rp; $rose(pins.ras_n) |-> ##1 pins.ras_n [*8]; endproperty
  a_rp: assert property (p_rp) else $error("precharge short");
  property p_ewr; $fell(pins.cas_n) && !pins.w_n |-> pins.g_n && !pins.dq_oe_n[0]; endproperty
  a_ewr: assert property (p_ewr) else $error("early write setup");
  property p_gap; gap_q <= 1700; endproperty
  a_gap: assert property (p_gap) else $error("refresh late");
  c_read: cover property (rd_valid);
  c_write: cover property ($fell(pins.cas_n) && !pins.w_n);
  c_page: cover property ($fell(pins.cas_n) && !$past(pins.ras_n, 8));
endmodule : dmc_ctrl_chk
bind dmc_ctrl dmc_ctrl_chk #(.PWR_CYC(PWR_CYC)) u_chk (.clk(clk), .nrst(nrst),
  .req_ready(req_ready), .rd_valid(rd_valid), .pins(pins));
`default_nettype wire

/* File: dv/dmc_ctrl_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module dmc_ctrl_tb;
  import dmc_pkg::*;
  logic              clk;
  logic              nrst;
  logic              req_valid;
  dmc_req_t          req;
  logic              req_page;
  logic              req_ready;
  logic              rd_valid;
  logic [DATA_W-1:0] rd_data;
  dmc_pins_t         pins;
  logic [DATA_W-1:0] mem_dq;
  logic [31:0]       seed;
  int                error_cnt;
  int                total_checks;
  int                mdl [int];
  int                q [$];
  // Shared data pins resolved from both drivers
  wire  [DATA_W-1:0] dq_i = (pins.dq_o & ~pins.dq_oe_n) | (mem_dq & pins.dq_oe_n);
  dmc_ctrl #(.PWR_CYC(20)) u_dut (.clk(clk), .nrst(nrst), .req_valid(req_valid), .req(req),
    .req_page(req_page), .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data),
    .pins(pins), .dq_i(dq_i));
  dmc_dram_mdl u_mem (.pins(pins), .dq(mem_dq));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Reads also carry random write data, which must never be stored
  task automatic op(input logic we, input int a, input logic pg);
    int n;
    @(posedge clk);
    seed = lfsr(seed);
    req_valid <= 1'b1;
    req <= '{we, a[13:6], a[5:0], seed[3:0]};
    req_page <= pg;
    n = 0;
    do @(negedge clk); while (!req_ready && ++n < 9999);
    chk(4'(n >= 9999), 4'h0);
    @(posedge clk);
    req_valid <= 1'b0;
    if (we) mdl[a] = seed[3:0];
    else begin
      do @(negedge clk); while (rd_valid !== 1'b1 && ++n < 9999);
      chk(4'(n >= 9999), 4'h0);
      chk(rd_data, 4'(mdl[a]));
    end
  endtask : op
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #400000;
    error_cnt++;
    close_out();
  end
  initial begin
    nrst = 1'b0;
    req_valid = 1'b0;
    req = '0;
    req_page = 1'b0;
    seed = 32'h080f;
    error_cnt = 0;
    total_checks = 0;
    repeat (20) @(posedge clk);
    chk({pins.ras_n, pins.cas_n, pins.w_n, pins.g_n}, 4'hf);
    chk(pins.dq_oe_n, 4'hf);
    nrst <= 1'b1;
    q = '{14'h0, 14'h3fff, 14'h1680, 14'h1681, 14'h16bf};
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      q.push_back(int'(seed[13:0]));
    end
    foreach (q[i]) op(1'b1, q[i], 1'b0);
    for (int i = 2; i < 5; i++) op(1'b1, q[i], 1'b1);
    // Second pass follows an idle span longer than one refresh interval
    for (int k = 0; k < 2; k++) begin
      foreach (q[i]) op(1'b0, q[i], 1'b1);
      repeat (1700) @(posedge clk);
    end
    close_out();
  end
endmodule : dmc_ctrl_tb
`default_nettype wire
